// ---- bench/sms_checker.sv ----
// Port checker for the serial master top.
// Assumes zero-wait single-word AHB-Lite transfers.
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.vh"
module sms_checker #(
  parameter OPTION_EN = 1
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic sck,
  input wire logic sdo,
  input wire logic irq
);
  logic ap, ap_q, wr_q, bsy_q, mode_q, mask_q;
  logic [9:0] a_q;
  logic [7:0] tx_q;
  logic [4:0] cnt, bidx;
  assign ap = hsel && hready && htrans[1] && (hsize == `SMS_HSIZE_WORD);
  assign bidx = (cnt - 5'h01) >> 1;
  // Cycles since the starting edge; a write while counting is dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      bsy_q <= 1'b0;
      mode_q <= 1'b1;
      mask_q <= 1'b0;
      a_q <= 10'h000;
      tx_q <= 8'h00;
      cnt <= 5'h00;
    end else begin
      ap_q <= ap;
      wr_q <= hwrite;
      a_q <= haddr[9:0];
      bsy_q <= cnt != 5'h00 && cnt < 5'h12;
      if (ap_q && wr_q && a_q == `SMS_ADDR_MODE) mode_q <= hwdata[0];
      if (ap_q && wr_q && a_q == `SMS_ADDR_MASK) mask_q <= hwdata[0];
      // Busy is already low while the count rests at its last value
      if (ap_q && wr_q && a_q == `SMS_ADDR_DATA && (cnt == 5'h00 || cnt == 5'h12) &&
          OPTION_EN != 0) begin
        cnt <= 5'h01;
        tx_q <= hwdata[7:0];
      end else if (cnt == 5'h12) cnt <= 5'h00;
      else if (cnt != 5'h00) cnt <= cnt + 5'h01;
    end
  end
  ////////////////////////////////////////
  sequence s_wr_data;
    ap && hwrite && haddr[9:0] == `SMS_ADDR_DATA && OPTION_EN != 0 ##1
      (cnt == 5'h00 || cnt == 5'h12);
  endsequence
  sequence s_run;
    cnt != 5'h00 && cnt < 5'h11;
  endsequence
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  start_shift_a: assert property (s_wr_data |=> !sck && sdo == $past(hwdata[7]))
    else $error("transfer did not start at once");
  sck_run_a: assert property (s_run |-> sck == !cnt[0])
    else $error("serial clock wrong during transfer");
  sdo_order_a: assert property (s_run |-> sdo == tx_q[3'h7 - bidx[2:0]])
    else $error("serial out bit order wrong");
  sdo_hold_a: assert property ($rose(sck) |-> $stable(sdo))
    else $error("serial out moved on a rising edge");
  sck_idle_a: assert property (cnt == 5'h00 && $stable(mode_q) |-> sck == mode_q)
    else $error("idle clock level wrong");
  status_read_a: assert property (ap_q && !wr_q && a_q == `SMS_ADDR_MODE |->
    hrdata == {24'h0, bsy_q, 6'h0, $past(mode_q)})
    else $error("mode register read wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  irq_raise_a: assert property (cnt == 5'h12 && mask_q |=> irq)
    else $error("interrupt missing after transfer");
  irq_mask_a: assert property (!mask_q && !$past(mask_q) |-> !irq)
    else $error("masked interrupt raised");
endmodule
`default_nettype wire

// ---- bench/sms_mem_model.sv ----
// Serial memory stand-in: answers one byte, records the byte received.
// Assumes the bench lowers select before the first clock edge.
`timescale 1ns/1ps
`default_nettype none
module sms_mem_model (
  // Pins
  input wire logic sck,
  input wire logic sdo,
  input wire logic cs_n,
  // Bench side
  input wire logic [7:0] reply,
  output logic sdi,
  output logic [7:0] got
);
  int n = 0;
  initial sdi = 1'b0;
  always @(negedge cs_n) begin
    n = 0;
    sdi <= reply[7];
  end
  always @(posedge sck) if (!cs_n) begin
    got <= {got[6:0], sdo};
    n = n + 1;
  end
  // Leading fall of mode 3 comes before any rise, so it must not advance
  always @(negedge sck) if (!cs_n && n > 0 && n < 8) sdi <= reply[3'h7 - n[2:0]];
  // A released line shows the inverse, never a stale bit
  always @(posedge cs_n) sdi <= ~sdi;
endmodule
`default_nettype wire

// ---- bench/sms_tb_top.sv ----
// Self-checking bench for the serial master top.
// Assumes zero-wait bus answers; the bench acts as the select pin.
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.vh"
`define CHK(n, e, g) cmp_count++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end
module sms_tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cs_n = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `SMS_HSIZE_WORD;
  logic [7:0] reply = 8'h00;
  wire logic [31:0] hrdata;
  wire logic [31:0] hrdata_off;
  wire logic hreadyout, hresp, sck, sdo, irq, sdi;
  wire logic [7:0] got;
  int bad_count = 0, cmp_count = 0, cyc = 0, i;
  // Row: mask, mode, byte sent, byte answered
  logic [31:0] rows [4] = '{32'h0101AA55, 32'h00000180, 32'h0100FF00, 32'h00015AA5};
  sms_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sdi(sdi), .sck(sck), .sdo(sdo), .irq(irq));
  // Second copy built without the option: it must never start a transfer
  sms_top #(.OPTION_EN(0)) DUT_OFF (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_off), .hreadyout(), .hresp(), .sdi(sdi), .sck(), .sdo(), .irq());
  sms_mem_model mem (.sck(sck), .sdo(sdo), .cs_n(cs_n), .reply(reply), .sdi(sdi), .got(got));
  initial forever #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict;
    end
  end
  ////////////////////////////////////////
  task print_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= `SMS_HTRANS_NONSEQ;
    haddr <= {22'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task rchk(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("read", e, q)
  endtask
  task wait_idle;
    q = 32'h80;
    while (q[7] !== 1'b0) bus(1'b0, `SMS_ADDR_MODE, 32'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `SMS_ADDR_MODE, {31'h0, rows[i][16]});
      bus(1'b1, `SMS_ADDR_MASK, {31'h0, rows[i][24]});
      reply <= rows[i][7:0];
      cs_n <= 1'b0;
      bus(1'b1, `SMS_ADDR_DATA, {24'h0, rows[i][15:8]});
      rchk(`SMS_ADDR_MODE, {24'h0, 8'h80 | rows[i][16]});
      `CHK("off busy", 1'b0, hrdata_off[7])
      wait_idle;
      cs_n <= 1'b1;
      `CHK("sck", rows[i][16], sck)
      rchk(`SMS_ADDR_DATA, {24'h0, rows[i][7:0]});
      `CHK("got", rows[i][15:8], got)
      `CHK("irq", rows[i][24], irq)
      rchk(`SMS_ADDR_STAT, 32'h1);
      bus(1'b1, `SMS_ADDR_STAT, 32'h1);
      rchk(`SMS_ADDR_STAT, 32'h0);
      `CHK("irq", 1'b0, irq)
    end
    // Second byte while busy must be dropped
    cs_n <= 1'b0;
    bus(1'b1, `SMS_ADDR_DATA, 32'hC3);
    bus(1'b1, `SMS_ADDR_DATA, 32'h3C);
    wait_idle;
    cs_n <= 1'b1;
    `CHK("got", 8'hC3, got)
    rchk(10'h3FC, 32'h0);
    // Reset in mid-transfer
    bus(1'b1, `SMS_ADDR_DATA, 32'h0F);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("sck", 1'b1, sck)
    `CHK("irq", 1'b0, irq)
    rchk(`SMS_ADDR_MODE, 32'h1);
    rchk(`SMS_ADDR_MASK, 32'h0);
    rchk(`SMS_ADDR_STAT, 32'h0);
    print_verdict;
  end
endmodule
bind sms_top sms_checker #(.OPTION_EN(OPTION_EN)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sck(sck), .sdo(sdo), .irq(irq));
`default_nettype wire

// ---- rtl/sms_map.vh ----
// Constants for the byte-wide serial master: register indices,
// byte addresses, field positions, reset values and timing.
// Included by every design file of the block; definitions only.
`ifndef SMS_MAP_VH
`define SMS_MAP_VH

// Register indices as printed, and byte address = 4 * index
`define SMS_IDX_MODE 8'h1E
`define SMS_IDX_DATA 8'h1F
`define SMS_IDX_STAT 8'h20
`define SMS_IDX_MASK 8'h21
`define SMS_ADDR_MODE {`SMS_IDX_MODE, 2'h0}
`define SMS_ADDR_DATA {`SMS_IDX_DATA, 2'h0}
`define SMS_ADDR_STAT {`SMS_IDX_STAT, 2'h0}
`define SMS_ADDR_MASK {`SMS_IDX_MASK, 2'h0}
`define SMS_ADDR_W 10

// Field positions
`define SMS_MODE_BIT 0
`define SMS_BUSY_BIT 7
`define SMS_EV_DONE 0

// Reset values
`define SMS_MODE_RST 1'h1
`define SMS_MASK_RST 1'h0

// Eight bits per transfer, two hclk phases per serial clock period
`define SMS_BITS 8
`define SMS_LAST_PHASE 5'h0F

// AHB encodings
`define SMS_HTRANS_NONSEQ 2'h2
`define SMS_HSIZE_WORD 3'h2

`endif

// ---- rtl/sms_shifter.v ----
// Eight-bit shift engine: drives the serial clock and data out and
// captures the synchronised serial input.
// Assumes sdi_sync already passed two flip-flops on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.vh"

module sms_shifter (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire start,
  input wire [7:0] tx_byte,
  input wire mode3,
  // Serial pins
  input wire sdi_sync,
  output reg sck_r,
  output reg sdo_r,
  // Status
  output reg busy_r,
  output reg done_r,
  output reg [7:0] rx_r
);

  reg active_r;
  reg [4:0] phase_r;
  reg [7:0] tx_r;
  reg [7:0] cap_r;
  reg rise_r;
  reg rise_d_r;

  ////////////////////////////////////////////////////////////////////
  // Phase sequencer: even phase low, odd phase high

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_r <= 1'b0;
      phase_r <= 5'h00;
      tx_r <= 8'h00;
      sck_r <= `SMS_MODE_RST;
      sdo_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      if (start && !busy_r) begin
        active_r <= 1'b1;
        phase_r <= 5'h00;
        tx_r <= {tx_byte[6:0], 1'b0};
        sdo_r <= tx_byte[7];
        sck_r <= 1'b0;
      end else if (active_r) begin
        phase_r <= phase_r + 5'h01;
        if (!phase_r[0]) begin
          // Every bit is sampled on this rising edge of the serial clock; data out moves on the fall
          sck_r <= 1'b1;
          rise_r <= 1'b1;
        end else if (phase_r == `SMS_LAST_PHASE) begin
          active_r <= 1'b0;
          sck_r <= mode3;
        end else begin
          sck_r <= 1'b0;
          sdo_r <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end else begin
        sck_r <= mode3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Capture: the sync lag is two cycles, so the sample is taken two
  // cycles after the rise, at the end of the phase after the high phase.

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_d_r <= 1'b0;
      cap_r <= 8'h00;
      rx_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rise_d_r <= rise_r;
      done_r <= 1'b0;
      if (rise_d_r) begin
        cap_r <= {cap_r[6:0], sdi_sync};
      end
      if (start && !busy_r) begin
        busy_r <= 1'b1;
      end else if (rise_d_r && !active_r && !rise_r) begin
        // Last bit captured: whole byte becomes visible at once
        rx_r <= {cap_r[6:0], sdi_sync};
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/sms_top.v ----
// Top of the byte-wide serial master with its AHB-Lite register slave,
// sticky done interrupt and input synchroniser.
// Assumes a single AHB-Lite master doing single word transfers, and an
// external memory whose select line is a general-purpose pin.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sms_map.vh"

module sms_top #(
  parameter OPTION_EN = 1
) (
  // AHB-Lite clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Serial pins
  input wire sdi,
  output wire sck,
  output wire sdo,
  // Interrupt
  output reg irq
);

  ////////////////////////////////////////////////////////////////////
  // Address decode helper

  function [2:0] dec_reg;
    input [31:0] a;
    begin
      if (a[`SMS_ADDR_W-1:0] == `SMS_ADDR_MODE) begin
        dec_reg = 3'h1;
      end else if (a[`SMS_ADDR_W-1:0] == `SMS_ADDR_DATA) begin
        dec_reg = 3'h2;
      end else if (a[`SMS_ADDR_W-1:0] == `SMS_ADDR_STAT) begin
        dec_reg = 3'h3;
      end else if (a[`SMS_ADDR_W-1:0] == `SMS_ADDR_MASK) begin
        dec_reg = 3'h4;
      end else begin
        dec_reg = 3'h0;
      end
    end
  endfunction

  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_MODE = 3'h1;
  localparam [2:0] SEL_DATA = 3'h2;
  localparam [2:0] SEL_STAT = 3'h3;
  localparam [2:0] SEL_MASK = 3'h4;

  wire opt_on;
  assign opt_on = (OPTION_EN != 0);

  ////////////////////////////////////////////////////////////////////
  // Address phase capture

  reg wr_pend_r;
  reg [2:0] wr_sel_r;
  wire addr_ok;
  wire [2:0] addr_sel;

  // Only whole-word transfers are decoded; others read zero
  assign addr_ok = hsel && hready && htrans[1] && (hsize == `SMS_HSIZE_WORD);
  assign addr_sel = dec_reg(haddr);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_sel_r <= SEL_NONE;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_sel_r <= addr_sel;
    end
  end

  // Zero wait state, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  reg mode3_r;
  reg stat_r;
  reg mask_r;
  wire wr_mode;
  wire wr_data;
  wire wr_stat;
  wire wr_mask;
  wire start;
  wire busy;
  wire done;
  wire [7:0] rx_byte;

  assign wr_mode = wr_pend_r && (wr_sel_r == SEL_MODE);
  assign wr_data = wr_pend_r && (wr_sel_r == SEL_DATA);
  assign wr_stat = wr_pend_r && (wr_sel_r == SEL_STAT);
  assign wr_mask = wr_pend_r && (wr_sel_r == SEL_MASK);

  // A write while busy is dropped; the byte in flight is kept intact
  assign start = wr_data && opt_on && !busy;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode3_r <= `SMS_MODE_RST;
      mask_r <= `SMS_MASK_RST;
    end else begin
      if (wr_mode) begin
        mode3_r <= hwdata[`SMS_MODE_BIT];
      end
      if (wr_mask) begin
        mask_r <= hwdata[`SMS_EV_DONE];
      end
    end
  end

  // Sticky done event; a new event wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= 1'b0;
    end else if (done) begin
      stat_r <= 1'b1;
    end else if (wr_stat && hwdata[`SMS_EV_DONE]) begin
      stat_r <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (stat_r || done) && mask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, loaded at the address phase so it stands from a flop
  // throughout the data phase.

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h00000000;
    case (addr_sel)
      SEL_MODE: begin
        rd_nxt[`SMS_MODE_BIT] = mode3_r;
        rd_nxt[`SMS_BUSY_BIT] = busy;
      end
      SEL_DATA: begin
        rd_nxt[7:0] = rx_byte;
      end
      SEL_STAT: begin
        rd_nxt[`SMS_EV_DONE] = stat_r;
      end
      SEL_MASK: begin
        rd_nxt[`SMS_EV_DONE] = mask_r;
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      // Reads of other sizes return zero rather than a stale word
      hrdata <= addr_ok ? rd_nxt : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial input synchroniser: the first stage feeds only the second

  reg sdi_s1_r;
  reg sdi_s2_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end else begin
      sdi_s1_r <= sdi;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shift engine. The serial clock is generated here only and no
  // external clock input exists, so the port cannot act as a slave.
  // The serial clock runs at the processor clock rate, taken as half
  // of hclk: one hclk phase low, one high.

  sms_shifter u_shift (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start),
    .tx_byte(hwdata[7:0]),
    .mode3(mode3_r),
    .sdi_sync(sdi_s2_r),
    .sck_r(sck),
    .sdo_r(sdo),
    .busy_r(busy),
    .done_r(done),
    .rx_r(rx_byte)
  );

endmodule

`default_nettype wire
